// [core/isbc_ctrl.sv]
// Seven-sink blink controller with its register file
`timescale 1ns/1ps
`include "isbc_regs.svh"
module isbc_ctrl
  import isbc_pkg::*;
#(
  // One 0.2 s unit in clock cycles: microseconds times megahertz
  parameter int UNIT_CYCLES = `ISBC_UNIT_NS / 1000 * `ISBC_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Register port
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  // Sink controls
  output logic      [`ISBC_NSINK-1:0]  sink_on,
  // Fade law to the current DACs
  output logic      [1:0]              fade_law_select,
  output logic                         fade_cubic_steps,
  output logic                         fade_cubic_profile
);

  isbc_state_t r;
  isbc_state_t n;

  // Off-time code of sink index i (0 is sink 1)
  function automatic logic [1:0] off_code(input logic [7:0] t1, input logic [7:0] t2,
                                          input int i);
    logic [1:0] c;
    c = 2'h0;
    if (i >= 4) begin
      c = t1[2*(i-4) +: 2]; // [RULE7]
    end else begin
      c = t2[2*i +: 2]; // [RULE12]
    end
    return c;
  endfunction

  function automatic logic [`ISBC_UNIT_W-1:0] on_units(input logic [1:0] c);
    logic [`ISBC_UNIT_W-1:0] u;
    case (c)
      2'h0:    u = `ISBC_ON_00;
      2'h1:    u = `ISBC_ON_01;
      2'h2:    u = `ISBC_ON_10;
      default: u = `ISBC_ON_11;
    endcase
    return u; // [RULE5]
  endfunction

  function automatic logic [`ISBC_UNIT_W-1:0] off_units(input logic [1:0] c);
    logic [`ISBC_UNIT_W-1:0] u;
    case (c)
      2'h1:    u = `ISBC_OFF_01;
      2'h2:    u = `ISBC_OFF_10;
      2'h3:    u = `ISBC_OFF_11;
      default: u = '0;
    endcase
    return u; // [RULE8]
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    return a == want;
  endfunction

  localparam logic [`ISBC_CYC_W-1:0] UNIT_LAST = `ISBC_CYC_W'(UNIT_CYCLES - 1);

  always_comb begin
    logic [1:0]              oc;
    logic                    unit_end;
    logic [`ISBC_UNIT_W-1:0] u1;
    oc       = 2'h0;
    unit_end = 1'b0;
    u1       = '0;
    n        = r;

    if (reg_wr) begin
      if (hit(reg_addr, `ISBC_ADDR_LAW)) begin
        n.law = reg_wdata[`ISBC_LAW_MSB:0]; // [RULE3]
      end
      if (hit(reg_addr, `ISBC_ADDR_EN)) begin
        n.en = reg_wdata[`ISBC_EN_MSB:0]; // [RULE4]
      end
      if (hit(reg_addr, `ISBC_ADDR_TIME1)) begin
        n.time1 = reg_wdata;
      end
      if (hit(reg_addr, `ISBC_ADDR_TIME2)) begin
        n.time2 = reg_wdata;
      end
    end

    if (reg_rd) begin
      case (1'b1)
        hit(reg_addr, `ISBC_ADDR_LAW):   n.rdata = {6'h00, r.law};
        hit(reg_addr, `ISBC_ADDR_EN):    n.rdata = {1'b0, r.en};
        hit(reg_addr, `ISBC_ADDR_TIME1): n.rdata = r.time1;
        hit(reg_addr, `ISBC_ADDR_TIME2): n.rdata = r.time2;
        default:                         n.rdata = `ISBC_RST_BYTE;
      endcase
    end

    // Each sink runs its own timer so enables at different times stay exact
    for (int i = 0; i < `ISBC_NSINK; i++) begin
      oc       = off_code(n.time1, n.time2, i);
      unit_end = (r.cyc[i] == UNIT_LAST);
      u1       = r.units[i] + `ISBC_UNIT_W'(1);
      if (!n.en[i]) begin
        n.phase[i] = PH_IDLE; // [RULE14]
        n.cyc[i]   = '0;
        n.units[i] = '0;
      end else begin
        case (r.phase[i])
          PH_IDLE: begin
            // Uses the written value so one write starts all its sinks together
            n.phase[i] = PH_LIT; // [RULE11] [RULE14]
            n.cyc[i]   = '0;
            n.units[i] = '0;
          end
          PH_LIT: begin
            if (oc == `ISBC_OFF_NONE) begin
              n.cyc[i]   = '0; // [RULE9]
              n.units[i] = '0;
            end else if (unit_end) begin
              n.cyc[i] = '0;
              if (u1 >= on_units(n.time1[`ISBC_ON_MSB:`ISBC_ON_LSB])) begin
                n.phase[i] = PH_DARK; // [RULE6] [RULE13]
                n.units[i] = '0;
              end else begin
                n.units[i] = u1;
              end
            end else begin
              n.cyc[i] = r.cyc[i] + `ISBC_CYC_W'(1);
            end
          end
          PH_DARK: begin
            if (oc == `ISBC_OFF_NONE) begin
              // Off time cleared mid-blink: fall back to steady on
              n.phase[i] = PH_LIT;
              n.cyc[i]   = '0;
              n.units[i] = '0;
            end else if (unit_end) begin
              n.cyc[i] = '0;
              if (u1 >= off_units(oc)) begin
                n.phase[i] = PH_LIT; // [RULE10]
                n.units[i] = '0;
              end else begin
                n.units[i] = u1;
              end
            end else begin
              n.cyc[i] = r.cyc[i] + `ISBC_CYC_W'(1);
            end
          end
          default: begin
            n.phase[i] = PH_IDLE;
            n.cyc[i]   = '0;
            n.units[i] = '0;
          end
        endcase
      end
      n.sink_on[i] = (n.phase[i] == PH_LIT);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      for (int i = 0; i < `ISBC_NSINK; i++) begin
        r.phase[i] <= PH_IDLE;
      end
    end else begin
      r <= n;
    end
  end

  assign reg_rdata          = r.rdata;
  assign sink_on            = r.sink_on;
  assign fade_law_select    = r.law;
  assign fade_cubic_steps   = r.law[1]; // [RULE1] [RULE2]
  assign fade_cubic_profile = r.law[1] & r.law[0]; // [RULE2]

  law_write_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
    reg_wr && reg_addr == `ISBC_ADDR_LAW |=> fade_law_select == $past(reg_wdata[1:0]))
    else $error("fade law not stored");

  law_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    reg_wr && reg_addr == `ISBC_ADDR_LAW |=> fade_cubic_steps == $past(reg_wdata[1]) &&
    fade_cubic_profile == ($past(reg_wdata[1:0]) == 2'h3))
    else $error("fade law mode wrong");

  enable_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
    reg_wr && reg_addr == `ISBC_ADDR_EN && reg_wdata[0] && !r.en[0] |=> sink_on[0])
    else $error("sink 1 did not start lit");

  disable_off_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
    reg_wr && reg_addr == `ISBC_ADDR_EN && !reg_wdata[6] |=> !sink_on[6] && r.cyc[6] == '0)
    else $error("sink 7 not turned off");

  steady_on_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
    r.en[4] && r.time1[1:0] == 2'h0 && !(reg_wr && reg_addr inside {`ISBC_ADDR_EN,
    `ISBC_ADDR_TIME1}) |=> sink_on[4])
    else $error("steady sink 5 dropped");

  on_bound_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
    r.phase[0] == PH_LIT |-> r.units[0] < on_units(r.time1[7:6]))
    else $error("on phase overran");

  off_bound_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
    r.phase[3] == PH_DARK |-> r.units[3] < off_units(r.time2[7:6]))
    else $error("off phase overran");

  sync_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
    reg_wr && reg_addr == `ISBC_ADDR_EN && reg_wdata[1:0] == 2'h3 && r.en[1:0] == 2'h0
    |=> sink_on[1:0] == 2'h3 && r.cyc[0] == r.cyc[1] && r.units[0] == r.units[1])
    else $error("sinks not started together");

endmodule

// [core/isbc_pkg.sv]
// Types shared by the blink controller
package isbc_pkg;
  `include "isbc_regs.svh"

  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_LIT  = 3'h2,
    PH_DARK = 3'h4
  } isbc_phase_t;

  typedef struct packed {
    logic [`ISBC_LAW_MSB:0]                     law;
    logic [`ISBC_EN_MSB:0]                      en;
    logic [7:0]                                 time1;
    logic [7:0]                                 time2;
    isbc_phase_t [`ISBC_NSINK-1:0]              phase;
    logic [`ISBC_NSINK-1:0][`ISBC_CYC_W-1:0]    cyc;
    logic [`ISBC_NSINK-1:0][`ISBC_UNIT_W-1:0]   units;
    logic [`ISBC_NSINK-1:0]                     sink_on;
    logic [7:0]                                 rdata;
  } isbc_state_t;
endpackage

// [core/isbc_regs.svh]
// Register map, field positions and timing constants of the blink controller
// What this block does
// (RULE1) Fade law codes 00 and 01 select square-law DAC with linear time steps.
// (RULE2) Fade law codes 10 and 11 select square-law DAC with one of two cubic profiles.
// (RULE3) Fade law select sits in bits 1:0; bits 7:2 are reserved.
// (RULE4) Enable register: sink n at bit n-1, bit 7 reserved; 1 on, 0 off.
// (RULE5) On-time field bits 7:6: 0.2 s, 0.6 s, 0.8 s, 1.2 s.
// (RULE6) With an off time set, an enabled sink stays on for the on time, then off.
// (RULE7) Off-time fields of sinks 7, 6, 5 sit at bits 5:4, 3:2, 1:0.
// (RULE8) Off-time code: 00 disabled, 01 0.6 s, 10 1.2 s, 11 1.8 s.
// (RULE9) Off time 00 with enable set keeps the sink on without blinking.
// (RULE10) After the off time the sink turns on again, repeating while enabled.
// (RULE11) Sinks enabled in one write start their sequences at the same moment.
// (RULE12) Second timing register holds off times of sinks 4 to 1, sink 4 at 7:6.
// (RULE13) On time is shared; each sink has its own phase timer from the clock.
// (RULE14) Enable rising starts with the on phase; clearing turns off and resets the timer.
`ifndef ISBC_REGS_SVH
`define ISBC_REGS_SVH

`define ISBC_ADDR_LAW      8'h1a
`define ISBC_ADDR_EN       8'h1b
`define ISBC_ADDR_TIME1    8'h1c
`define ISBC_ADDR_TIME2    8'h1d

`define ISBC_LAW_MSB       1
`define ISBC_EN_MSB        6
`define ISBC_ON_MSB        7
`define ISBC_ON_LSB        6
`define ISBC_NSINK         7
`define ISBC_RST_BYTE      8'h00

// Every time is a whole number of 0.2 s units
`define ISBC_UNIT_NS       200000000
`define ISBC_CLK_MHZ       40
`define ISBC_CYC_W         23
`define ISBC_UNIT_W        4
`define ISBC_ON_00         4'h1
`define ISBC_ON_01         4'h3
`define ISBC_ON_10         4'h4
`define ISBC_ON_11         4'h6
`define ISBC_OFF_01        4'h3
`define ISBC_OFF_10        4'h6
`define ISBC_OFF_11        4'h9
`define ISBC_OFF_NONE      2'h0

`endif

// [verif/isbc_ctrl_tb_top.sv]
// Self-checking bench for the seven-sink blink controller
`timescale 1ns/1ps
`include "isbc_regs.svh"
module isbc_ctrl_tb_top;
  import isbc_pkg::*;
  localparam int UC = 4;
  localparam int ON_U[4]  = '{1, 3, 4, 6};
  localparam int OFF_U[4] = '{0, 3, 6, 9};
  logic       clock     = 1'b0;
  logic       rst_n     = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [6:0] sink_on;
  logic [1:0] fade_law_select;
  logic       fade_cubic_steps;
  logic       fade_cubic_profile;
  int         miscompares = 0;
  int         n_compared  = 0;
  // Reference model
  logic [7:0] m_law, m_en, m_t1, m_t2, m_rexp;
  logic [6:0] m_lit;
  logic       m_rpend;
  int         m_cnt[7];

  isbc_ctrl #(.UNIT_CYCLES(UC)) i_isbc_ctrl (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sink_on(sink_on), .fade_law_select(fade_law_select),
    .fade_cubic_steps(fade_cubic_steps), .fade_cubic_profile(fade_cubic_profile)
  );

  initial forever #12.5 clock = ~clock;

  function automatic logic [7:0] m_read(input logic [7:0] a);
    case (a)
      `ISBC_ADDR_LAW:   return m_law;
      `ISBC_ADDR_EN:    return m_en;
      `ISBC_ADDR_TIME1: return m_t1;
      `ISBC_ADDR_TIME2: return m_t2;
      default:          return 8'h00;
    endcase
  endfunction

  function automatic int off_of(input int i);
    return OFF_U[i < 4 ? m_t2[2*i +: 2] : m_t1[2*(i-4) +: 2]];
  endfunction

  // Sees inputs as the design does, before this edge's driver updates land
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {m_law, m_en, m_t1, m_t2, m_rexp, m_lit, m_rpend} = '0;
    end else begin
      m_rpend = reg_rd;
      m_rexp  = m_read(reg_addr);
      for (int i = 0; i < 7; i++) begin
        if (m_en[i] && off_of(i) != 0) begin
          m_cnt[i]--;
          if (m_cnt[i] == 0) begin
            m_lit[i] = !m_lit[i];
            m_cnt[i] = (m_lit[i] ? ON_U[m_t1[7:6]] : off_of(i)) * UC;
          end
        end
      end
      if (reg_wr) begin
        case (reg_addr)
          `ISBC_ADDR_LAW:   m_law = {6'h00, reg_wdata[1:0]};
          `ISBC_ADDR_TIME1: m_t1 = reg_wdata;
          `ISBC_ADDR_TIME2: m_t2 = reg_wdata;
          `ISBC_ADDR_EN: begin
            for (int i = 0; i < 7; i++) begin
              if (reg_wdata[i] && !m_en[i]) begin
                m_lit[i] = 1'b1;
                m_cnt[i] = ON_U[m_t1[7:6]] * UC;
              end
            end
            m_lit = m_lit & reg_wdata[6:0];
            m_en  = {1'b0, reg_wdata[6:0]};
          end
          default: ;
        endcase
      end
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(negedge clock) begin
    if (rst_n) begin
      check({1'b0, sink_on}, {1'b0, m_lit});
      check({6'h00, fade_law_select}, m_law);
      check({6'h00, fade_cubic_steps, fade_cubic_profile},
            {6'h00, m_law[1], m_law[1:0] == 2'h3});
      if (m_rpend) check(reg_rdata, m_rexp);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run needs about 1300 cycles
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h15754a1e));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    wr(8'h1e, 8'hff);
    for (int a = 8'h1a; a <= 8'h1e; a++) rd(8'(a));
    for (int k = 0; k < 4; k++) begin
      wr(`ISBC_ADDR_LAW, {6'($urandom), 2'(k)});
      rd(`ISBC_ADDR_LAW);
    end
    wr(`ISBC_ADDR_EN, 8'hff);
    rd(`ISBC_ADDR_EN);
    repeat (20) @(posedge clock);
    wr(`ISBC_ADDR_EN, 8'h00);
    // Times change only while all sinks are off, so no mid-phase retiming
    for (int k = 0; k < 8; k++) begin
      wr(`ISBC_ADDR_TIME1, {2'(k), 6'($urandom)});
      wr(`ISBC_ADDR_TIME2, 8'($urandom));
      rd(`ISBC_ADDR_TIME1);
      rd(`ISBC_ADDR_TIME2);
      wr(`ISBC_ADDR_EN, 8'($urandom));
      repeat (70) @(posedge clock);
      wr(`ISBC_ADDR_EN, 8'($urandom));
      repeat (70) @(posedge clock);
      wr(`ISBC_ADDR_EN, 8'h00);
    end
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule
